// file: sra_setpoint_relay_alarm_logic.sv
// Four-setpoint alarm comparison, first-relay timers and pump band, with the setup menu.
`timescale 1ns/1ps
`default_nettype none
`include "sra_defines.svh"

module sra_setpoint_relay_alarm_logic
   import sra_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `SRA_TICK_CYCLES,
   parameter logic [15:0] BAND_HOLD_SELECT_BAND = `SRA_BAND_HOLD_SELECT_BAND
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic signed [15:0] reading_i,
   input wire logic key_prog_i,
   input wire logic key_up_i,
   input wire logic key_down_i,
   input wire logic lockout_i,
   output logic [3:0] relay_o,
   output logic [3:0] annunciator_o,
   output sra_menu_t menu_step_o,
   output logic [1:0] sense_digit_o,
   output sra_cfg_t cfg_o
);

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   sra_menu_t st_r, st_nxt;
   logic [1:0] dig_r, dig_nxt;
   sra_cfg_t cfg_r, cfg_nxt;
   logic [3:0] cmp_r, cmp_nxt;
   logic band_r, band_nxt;
   logic [TW-1:0] tick_r, tick_nxt;
   logic [13:0] sec_r, sec_nxt;
   logic [3:0] relay_r, relay_nxt;
   logic pump_act;
   logic cond1;
   logic edit;

   // Saturating one-count step used by every numeric menu entry.
   function automatic logic [15:0] step_val(input logic [15:0] v, input logic up,
                                            input logic [15:0] lo, input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if (up && ($signed(v) < $signed(hi))) begin
         r = v + 16'h0001;
      end else if (!up && ($signed(v) > $signed(lo))) begin
         r = v - 16'h0001;
      end
      return r;
   endfunction

   // ****************************************************************
   // Setup menu
   // ****************************************************************
   // Lockout only blocks edits; stepping through the menu stays possible for viewing.
   assign edit = (key_up_i ^ key_down_i) && !lockout_i;

   always_comb begin
      st_nxt = st_r;
      dig_nxt = dig_r;
      cfg_nxt = cfg_r;
      if (st_r == SRA_IDLE) begin
         if (key_prog_i && key_up_i) begin
            st_nxt = SRA_LVL1;
         end
      end else if (key_prog_i) begin
         case (st_r)
            SRA_LVL1: st_nxt = SRA_MAKE;
            SRA_MAKE: st_nxt = SRA_BRK;
            SRA_BRK: st_nxt = SRA_HYS1;
            SRA_HYS1: st_nxt = SRA_PUMP;
            SRA_PUMP: st_nxt = SRA_LVL2;
            SRA_LVL2: st_nxt = SRA_HYS2;
            SRA_HYS2: st_nxt = SRA_LVL3;
            SRA_LVL3: st_nxt = SRA_HYS3;
            SRA_HYS3: st_nxt = SRA_LVL4;
            SRA_LVL4: st_nxt = SRA_HYS4;
            SRA_HYS4: st_nxt = SRA_SENSE;
            SRA_SENSE: begin
               if (dig_r == `SRA_LAST_DIGIT) begin
                  st_nxt = SRA_IDLE;
                  dig_nxt = 2'h0;
               end else begin
                  dig_nxt = dig_r + 2'h1;
               end
            end
            default: st_nxt = SRA_IDLE;
         endcase
      end else if (edit) begin
         case (st_r)
            SRA_LVL1: cfg_nxt.setpoint[0] = step_val(cfg_r.setpoint[0], key_up_i,
                                                    `SRA_SP_MIN, `SRA_SP_MAX);
            SRA_LVL2: cfg_nxt.setpoint[1] = step_val(cfg_r.setpoint[1], key_up_i,
                                                    `SRA_SP_MIN, `SRA_SP_MAX);
            SRA_LVL3: cfg_nxt.setpoint[2] = step_val(cfg_r.setpoint[2], key_up_i,
                                                    `SRA_SP_MIN, `SRA_SP_MAX);
            SRA_LVL4: cfg_nxt.setpoint[3] = step_val(cfg_r.setpoint[3], key_up_i,
                                                    `SRA_SP_MIN, `SRA_SP_MAX);
            SRA_MAKE: cfg_nxt.make_delay = 14'(step_val({2'h0, cfg_r.make_delay}, key_up_i,
                                                        `SRA_DELAY_MIN, `SRA_DELAY_MAX));
            SRA_BRK: cfg_nxt.break_delay = 14'(step_val({2'h0, cfg_r.break_delay}, key_up_i,
                                                        `SRA_DELAY_MIN, `SRA_DELAY_MAX));
            SRA_HYS1: cfg_nxt.band_hold_select[0] = key_up_i;
            SRA_HYS2: cfg_nxt.band_hold_select[1] = key_up_i;
            SRA_HYS3: cfg_nxt.band_hold_select[2] = key_up_i;
            SRA_HYS4: cfg_nxt.band_hold_select[3] = key_up_i;
            SRA_PUMP: cfg_nxt.fill_drain_band_mode = key_up_i;
            SRA_SENSE: cfg_nxt.relay_sense_pattern[dig_r] = key_up_i;
            default: cfg_nxt = cfg_r;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= SRA_IDLE;
         dig_r <= 2'h0;
         cfg_r.setpoint <= {4{`SRA_SP_RESET}};
         cfg_r.make_delay <= `SRA_DELAY_RESET;
         cfg_r.break_delay <= `SRA_DELAY_RESET;
         cfg_r.band_hold_select <= `SRA_HYS_RESET;
         cfg_r.fill_drain_band_mode <= `SRA_PUMP_RESET;
         cfg_r.relay_sense_pattern <= `SRA_SENSE_RESET;
      end else begin
         st_r <= st_nxt;
         dig_r <= dig_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // ****************************************************************
   // Comparators
   // ****************************************************************
   // With hysteresis on, an active alarm only drops once the reading is a band past the
   // setpoint, which stops relay chatter on a noisy reading near the threshold.
   for (genvar g = 0; g < 4; g++) begin : g_cmp
      logic signed [16:0] sp;
      logic signed [16:0] rd;
      logic signed [16:0] bd;
      assign sp = 17'($signed(cfg_r.setpoint[g]));
      assign rd = 17'(reading_i);
      assign bd = (cfg_r.band_hold_select[g] && cmp_r[g]) ? 17'(BAND_HOLD_SELECT_BAND) : 17'h00000;
      always_comb begin
         if (cfg_r.relay_sense_pattern[g]) begin
            cmp_nxt[g] = rd > (sp - bd);
         end else begin
            cmp_nxt[g] = rd < (sp + bd);
         end
      end
   end

   // Pump band latch for the first relay.
   assign pump_act = cfg_r.fill_drain_band_mode &&
                     ($signed(cfg_r.setpoint[1]) > $signed(cfg_r.setpoint[0]));

   always_comb begin
      band_nxt = band_r;
      if (!cfg_r.relay_sense_pattern[0]) begin
         if (reading_i < $signed(cfg_r.setpoint[0])) begin
            band_nxt = 1'b1;
         end else if (reading_i >= $signed(cfg_r.setpoint[1])) begin
            band_nxt = 1'b0;
         end
      end else begin
         if (reading_i > $signed(cfg_r.setpoint[1])) begin
            band_nxt = 1'b1;
         end else if (reading_i <= $signed(cfg_r.setpoint[0])) begin
            band_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmp_r <= 4'h0;
         band_r <= 1'b0;
      end else begin
         cmp_r <= cmp_nxt;
         band_r <= band_nxt;
      end
   end

   // ****************************************************************
   // First relay timers and relay outputs
   // ****************************************************************
   assign cond1 = pump_act ? band_r : cmp_r[0];

   // The tick counter restarts with the timer, so a delay of N seconds is exact rather
   // than up to one second short.
   always_comb begin
      tick_nxt = tick_r;
      sec_nxt = sec_r;
      relay_nxt = {cmp_r[3:1], relay_r[0]};
      if (cond1 == relay_r[0]) begin
         tick_nxt = '0;
         sec_nxt = 14'h0000;
      end else if (sec_r >= (cond1 ? cfg_r.make_delay : cfg_r.break_delay)) begin
         relay_nxt[0] = cond1;
         tick_nxt = '0;
         sec_nxt = 14'h0000;
      end else if (tick_r == TICK_LAST) begin
         tick_nxt = '0;
         sec_nxt = sec_r + 14'h0001;
      end else begin
         tick_nxt = tick_r + TW'(1);
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_r <= '0;
         sec_r <= 14'h0000;
         relay_r <= 4'h0;
      end else begin
         tick_r <= tick_nxt;
         sec_r <= sec_nxt;
         relay_r <= relay_nxt;
      end
   end

   assign relay_o = relay_r;
   assign annunciator_o = relay_r;
   assign menu_step_o = st_r;
   assign sense_digit_o = dig_r;
   assign cfg_o = cfg_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_direct_relay;
      @(posedge clock_i) disable iff (!reset_n_i)
      (!cfg_r.band_hold_select[2] && $stable(cfg_r) &&
       (cfg_r.relay_sense_pattern[2] ? (reading_i > $signed(cfg_r.setpoint[2])) :
        (reading_i < $signed(cfg_r.setpoint[2]))))
      |=> ##1 relay_o[2];
   endproperty
   a_direct_relay: assert property (p_direct_relay) else $error("third relay late");

   property p_low_sense;
      @(posedge clock_i) disable iff (!reset_n_i)
      (!cfg_r.relay_sense_pattern[1] && (reading_i < $signed(cfg_r.setpoint[1])))
      |=> cmp_r[1];
   endproperty
   a_low_sense: assert property (p_low_sense) else $error("low sense missed");

   property p_make;
      @(posedge clock_i) disable iff (!reset_n_i)
      $rose(relay_o[0]) |-> $past(cond1) && ($past(sec_r) >= $past(cfg_r.make_delay));
   endproperty
   a_make: assert property (p_make) else $error("relay one made early");

   property p_break;
      @(posedge clock_i) disable iff (!reset_n_i)
      $fell(relay_o[0]) |-> !$past(cond1) && ($past(sec_r) >= $past(cfg_r.break_delay));
   endproperty
   a_break: assert property (p_break) else $error("relay one broke early");

   property p_restart;
      @(posedge clock_i) disable iff (!reset_n_i)
      (cond1 == relay_r[0]) |=> (sec_r == 14'h0000) && (tick_r == '0);
   endproperty
   a_restart: assert property (p_restart) else $error("timer not restarted");

   property p_enter;
      @(posedge clock_i) disable iff (!reset_n_i)
      (st_r == SRA_IDLE && key_prog_i && key_up_i) |=> (st_r == SRA_LVL1) ##1 $stable(cfg_r);
   endproperty
   a_enter: assert property (p_enter) else $error("menu did not open");

   property p_order;
      @(posedge clock_i) disable iff (!reset_n_i)
      (st_r == SRA_BRK && key_prog_i) |=> (st_r == SRA_HYS1);
   endproperty
   a_order: assert property (p_order) else $error("menu order broken");

   property p_lock;
      @(posedge clock_i) disable iff (!reset_n_i)
      lockout_i |=> $stable(cfg_r);
   endproperty
   a_lock: assert property (p_lock) else $error("edit under lockout");

   property p_fill;
      @(posedge clock_i) disable iff (!reset_n_i)
      (pump_act && !cfg_r.relay_sense_pattern[0] && (reading_i < $signed(cfg_r.setpoint[0])))
      |=> band_r;
   endproperty
   a_fill: assert property (p_fill) else $error("fill band not set");

   property p_empty;
      @(posedge clock_i) disable iff (!reset_n_i)
      (pump_act && cfg_r.relay_sense_pattern[0] && (reading_i <= $signed(cfg_r.setpoint[0])))
      |=> !band_r;
   endproperty
   a_empty: assert property (p_empty) else $error("empty band not cleared");

   property p_plain;
      @(posedge clock_i) disable iff (!reset_n_i)
      (!pump_act && (cfg_r.make_delay == 14'h0000) && (cfg_r.break_delay == 14'h0000))
      |=> (relay_o[0] == $past(cmp_r[0]));
   endproperty
   a_plain: assert property (p_plain) else $error("relay one off its comparison");

   c_make: cover property (@(posedge clock_i) disable iff (!reset_n_i) $rose(relay_o[0]));
   c_break: cover property (@(posedge clock_i) disable iff (!reset_n_i) $fell(relay_o[0]));
   c_pump: cover property (@(posedge clock_i) disable iff (!reset_n_i) pump_act && band_r);
   c_done: cover property (@(posedge clock_i) disable iff (!reset_n_i)
                           st_r == SRA_SENSE ##1 st_r == SRA_IDLE);

endmodule // sra_setpoint_relay_alarm_logic
`default_nettype wire

// file: sra_defines.svh
// Constants for the setpoint relay alarm logic: limits, reset values and timing.
`ifndef SRA_DEFINES_SVH
`define SRA_DEFINES_SVH

// ****************************************************************
// Value limits
// ****************************************************************
`define SRA_SP_MAX 16'h270f
`define SRA_SP_MIN 16'hf831
`define SRA_DELAY_MAX 16'h270f
`define SRA_DELAY_MIN 16'h0000

// ****************************************************************
// Reset values
// ****************************************************************
`define SRA_SP_RESET 16'h270f
`define SRA_DELAY_RESET 14'h0000
`define SRA_HYS_RESET 4'h0
`define SRA_SENSE_RESET 4'hf
`define SRA_PUMP_RESET 1'b0

// ****************************************************************
// Timing, hysteresis band and last sense digit
// ****************************************************************
`define SRA_TICK_MS 1000
`define SRA_CLK_KHZ 200000
`define SRA_TICK_CYCLES (`SRA_TICK_MS * `SRA_CLK_KHZ)
`define SRA_BAND_HOLD_SELECT_BAND 16'h0002
`define SRA_LAST_DIGIT 2'h3

`endif

// file: sra_pkg.sv
// Types shared by the setpoint relay alarm logic.
`default_nettype none
package sra_pkg;

   // ****************************************************************
   // Menu steps
   // ****************************************************************
   typedef enum logic [13:0] {
      SRA_IDLE  = 14'h0001,
      SRA_LVL1  = 14'h0002,
      SRA_MAKE  = 14'h0004,
      SRA_BRK   = 14'h0008,
      SRA_HYS1  = 14'h0010,
      SRA_PUMP  = 14'h0020,
      SRA_LVL2  = 14'h0040,
      SRA_HYS2  = 14'h0080,
      SRA_LVL3  = 14'h0100,
      SRA_HYS3  = 14'h0200,
      SRA_LVL4  = 14'h0400,
      SRA_HYS4  = 14'h0800,
      SRA_SENSE = 14'h1000,
      SRA_SPARE = 14'h2000
   } sra_menu_t;

   // ****************************************************************
   // Configuration set
   // ****************************************************************
   typedef struct packed {
      logic [3:0][15:0] setpoint;
      logic [13:0] make_delay;
      logic [13:0] break_delay;
      logic [3:0] band_hold_select;
      logic fill_drain_band_mode;
      logic [3:0] relay_sense_pattern;
   } sra_cfg_t;

endpackage
`default_nettype wire

// file: sra_panel_model.sv
// Front-panel model: program, up and down keys and the lockout switch.
`timescale 1ns/1ps
`default_nettype none
module sra_panel_model (
   input wire logic clock_i,
   output logic key_prog_o,
   output logic key_up_o,
   output logic key_down_o,
   output logic lockout_o
);
   // ****************************************************************
   // Keys
   // ****************************************************************
   initial begin
      key_prog_o = 1'b0;
      key_up_o = 1'b0;
      key_down_o = 1'b0;
      lockout_o = 1'b0;
   end

   // A press is one high cycle between falling edges, so exactly one rising edge sees it.
   // Program together with up is the menu entry pair.
   task automatic press(input logic p, input logic u, input logic d);
      @(negedge clock_i);
      key_prog_o = p;
      key_up_o = u;
      key_down_o = d;
      @(negedge clock_i);
      key_prog_o = 1'b0;
      key_up_o = 1'b0;
      key_down_o = 1'b0;
   endtask

   task automatic set_lock(input logic l);
      @(negedge clock_i);
      lockout_o = l;
   endtask
endmodule // sra_panel_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the setpoint relay alarm logic.
`timescale 1ns/1ps
`default_nettype none
module tb
   import sra_pkg::*;
;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam int unsigned TICK = 10;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic signed [15:0] reading = 16'sd0;
   logic kp, ku, kd, lock;
   logic [3:0] relay, ann;
   sra_menu_t step;
   logic [1:0] digit;
   sra_cfg_t cfg;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   sra_menu_t nx [15] = '{SRA_MAKE, SRA_BRK, SRA_HYS1, SRA_PUMP, SRA_LVL2, SRA_HYS2, SRA_LVL3,
      SRA_HYS3, SRA_LVL4, SRA_HYS4, SRA_SENSE, SRA_SENSE, SRA_SENSE, SRA_SENSE, SRA_IDLE};

   always #2.5 clock = ~clock;

   sra_panel_model sra_panel_model_inst (.clock_i(clock), .key_prog_o(kp), .key_up_o(ku),
      .key_down_o(kd), .lockout_o(lock));

   sra_setpoint_relay_alarm_logic #(.TICK_CYCLES(TICK)) sra_setpoint_relay_alarm_logic_inst (
      .clock_i(clock), .reset_n_i(reset_n), .reading_i(reading), .key_prog_i(kp),
      .key_up_i(ku), .key_down_i(kd), .lockout_i(lock), .relay_o(relay),
      .annunciator_o(ann), .menu_step_o(step), .sense_digit_o(digit), .cfg_o(cfg));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // Four falling edges cover the comparator, band latch and relay flops.
   task automatic rd(input logic signed [15:0] v, input int n);
      @(negedge clock);
      reading = v;
      repeat (n) @(negedge clock);
   endtask

   task automatic wait_relay(input logic v, input int lim);
      int n;
      n = 0;
      while (relay[0] !== v && n < lim) begin
         @(negedge clock);
         n++;
      end
   endtask

   // Edits per step, then program; u and d count up and down presses at each step.
   task automatic walk(input int u [15], input int d [15]);
      sra_panel_model_inst.press(1'b1, 1'b1, 1'b0);
      check("menu_step", step, SRA_LVL1);
      for (int i = 0; i < 15; i++) begin
         repeat (u[i]) sra_panel_model_inst.press(1'b0, 1'b1, 1'b0);
         repeat (d[i]) sra_panel_model_inst.press(1'b0, 1'b0, 1'b1);
         sra_panel_model_inst.press(1'b1, 1'b0, 1'b0);
         check("menu_step", step, nx[i]);
         if (i >= 11 && i < 14) check("sense_digit", digit, i - 10);
      end
   endtask

   // ****************************************************************
   // Timeout
   // ****************************************************************
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         results();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (8) @(negedge clock);
      reset_n = 1'b1;
      check("relay", relay, 4'h0);
      for (int i = 0; i < 4; i++) check("setpoint", cfg.setpoint[i], 16'h270f);
      check("delays", {cfg.make_delay, cfg.break_delay}, 28'h0);
      check("band_hold", cfg.band_hold_select, 4'h0);
      check("pump", cfg.fill_drain_band_mode, 1'b0);
      check("sense", cfg.relay_sense_pattern, 4'hf);
      check("menu_step", step, SRA_IDLE);
      // A lone up key in idle must neither open the menu nor edit anything.
      sra_panel_model_inst.press(1'b0, 1'b1, 1'b0);
      check("menu_step", step, SRA_IDLE);
      check("setpoint_one", cfg.setpoint[0], 16'h270f);
      sra_panel_model_inst.set_lock(1'b1);
      walk('{0, 3, 2, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0},
           '{9, 0, 0, 0, 0, 4, 0, 10, 0, 0, 0, 0, 0, 1, 0});
      check("locked_cfg", cfg.make_delay, 14'h0);
      check("locked_setpoint", cfg.setpoint[0], 16'h270f);
      sra_panel_model_inst.set_lock(1'b0);
      // Setpoint four stays parked at 9999 with high sense so it never indicates.
      walk('{0, 3, 2, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0},
           '{9, 0, 0, 0, 0, 4, 0, 10, 0, 0, 0, 0, 0, 1, 0});
      check("setpoint_one", cfg.setpoint[0], 16'h2706);
      check("setpoint_two", cfg.setpoint[1], 16'h270b);
      check("setpoint_three", cfg.setpoint[2], 16'h2705);
      check("setpoint_four", cfg.setpoint[3], 16'h270f);
      check("delays", {cfg.make_delay, cfg.break_delay}, {14'h3, 14'h2});
      check("band_hold", cfg.band_hold_select, 4'h2);
      check("sense", cfg.relay_sense_pattern, 4'hb);
      rd(16'sd0, 4);
      check("relay_three_low", relay[2], 1'b1);
      check("annunciator_three", ann[2], 1'b1);
      rd(16'sd9989, 4);
      check("relay_three_edge", relay[2], 1'b0);
      rd(16'sd9999, 4);
      check("relay_two_high", relay[1], 1'b1);
      check("relay_four_parked", relay[3], 1'b0);
      rd(16'sd9994, 4);
      check("relay_two_hold", relay[1], 1'b1);
      rd(16'sd9992, 4);
      check("relay_two_release", relay[1], 1'b0);
      rd(16'sd0, 4);
      // Make delay 3 s at 10 cycles a second; a short dip must restart the count.
      rd(16'sd9991, 20);
      check("make_early", relay[0], 1'b0);
      rd(16'sd0, 2);
      rd(16'sd9991, 25);
      check("make_restart", relay[0], 1'b0);
      wait_relay(1'b1, 20);
      check("make_done", relay[0], 1'b1);
      check("annunciator_one", ann[0], 1'b1);
      rd(16'sd0, 12);
      check("break_early", relay[0], 1'b1);
      wait_relay(1'b0, 20);
      check("break_done", relay[0], 1'b0);
      // Delays to zero and pump on, high sense: emptying band.
      walk('{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
           '{0, 3, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0});
      check("pump", cfg.fill_drain_band_mode, 1'b1);
      rd(16'sd9993, 4);
      check("band_inside", relay[0], 1'b0);
      rd(16'sd9996, 4);
      check("empty_set", relay[0], 1'b1);
      rd(16'sd9993, 4);
      check("empty_hold", ann[0], 1'b1);
      rd(16'sd9990, 4);
      check("empty_clear", relay[0], 1'b0);
      // Low sense on setpoint one turns the band into filling.
      walk('{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
           '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0});
      rd(16'sd9989, 4);
      check("fill_set", relay[0], 1'b1);
      rd(16'sd9993, 4);
      check("fill_hold", ann[0], 1'b1);
      rd(16'sd9995, 4);
      check("fill_clear", relay[0], 1'b0);
      results();
   end
endmodule // tb
`default_nettype wire
